/* File: eech_core.sv */
`default_nettype none
module eech_core
	import eech_pkg::*;
#(
	parameter int            DELAY_WORDS = 65536,
	parameter logic [15:0]   FADE_STEP   = 16'h0100,
	parameter logic [15:0]   OVF_LIMIT   = 16'h7000
) (
	input  wire logic                          clk,
	input  wire logic                          srst,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [7:0]                    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	output logic                               irq,
	input  wire logic [eech_pkg::LEVEL_W-1:0]  effectSampleIn,
	output logic      [eech_pkg::LEVEL_W-1:0]  effectSampleOut,
	input  wire logic [eech_pkg::LEVEL_W-1:0]  output_level_value,
	output logic      [eech_pkg::LEVEL_W-1:0]  outputLevelCtrl,
	output logic                               level_overflow_pulse,
	output logic                               microcode_mem_free,
	output logic                               microcodeMuxSel,
	output logic      [eech_pkg::MC_ADDR_W-1:0] microcode_addr_bus,
	input  wire logic [eech_pkg::MC_WORD_W-1:0] microcodeWordIn,
	output logic      [eech_pkg::MC_WORD_W-1:0] microcodeWordOut,
	output logic                               microcodeWordOe,
	output logic                               microcodeWe,
	output logic      [eech_pkg::MC_WORD_W-1:0] instrWord,
	output logic                               delayClrWe,
	output logic      [eech_pkg::DLY_ADDR_W-1:0] delayClrAddr
);
	import eech_pkg::*;

	localparam logic [DLY_ADDR_W-1:0] DLY_LAST    = DLY_ADDR_W'(DELAY_WORDS - 1);
	localparam logic [3:0]            SLOT_LAST   = 4'(MC_SLOT_CYC - 1);
	localparam logic [3:0]            FETCH_LAST  = 4'(MC_FETCH_CYC - 1);
	localparam logic [3:0]            WRITE_SLOT  = 4'(MC_FETCH_CYC + 1);
	localparam logic [11:0]           SAMPLE_LAST = 12'(SAMPLE_CYC - 1);

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	logic                 ack_q, ack_d;
	logic [31:0]          rdat_q, rdat_d;
	logic [4:0]           ctrl_q, ctrl_d;
	logic [NUM_EVT-1:0]   mask_q, mask_d;
	logic [MC_ADDR_W-1:0] cpuAddr_q, cpuAddr_d;
	logic [MC_WORD_W-1:0] cpuData_q, cpuData_d;
	logic                 pending_q, pending_d;
	logic                 irq_q, irq_d;
	logic                 wbReq, wbWrite;
	logic [NUM_EVT-1:0]   evtSet, evtClr, evtFlags, statusView;
	logic                 ovfSeen;
	logic                 mcWriteNow;
	eech_gate_state_t     gate_q, gate_d;
	logic [15:0]          gain_q, gain_d;

	assign wbReq   = wb_cyc_i & wb_stb_i;
	// A write lands on the same edge that the master sees ack high.
	assign wbWrite = wbReq & wb_we_i & ack_q;

	always_comb begin
		ack_d     = wbReq & ~ack_q;
		rdat_d    = rdat_q;
		ctrl_d    = ctrl_q;
		mask_d    = mask_q;
		cpuAddr_d = cpuAddr_q;
		cpuData_d = cpuData_q;
		pending_d = pending_q;
		evtClr    = '0;
		if (wbReq & ~ack_q) begin
			case (wb_adr_i)
				REG_CTRL:   rdat_d = {27'h0000000, ctrl_q};
				REG_STATUS: rdat_d = {29'h00000000, statusView};
				REG_MASK:   rdat_d = {29'h00000000, mask_q};
				REG_MCADDR: rdat_d = {21'h000000, cpuAddr_q};
				REG_MCDATA: rdat_d = {16'h0000, cpuData_q};
				REG_STATE:  rdat_d = {gain_q, 13'h0000, ctrl_q[CTRL_MUTE], gate_q != GATE_IDLE, pending_q};
				default:    rdat_d = 32'h00000000;
			endcase
		end
		if (wbWrite & wb_sel_i[0]) begin
			case (wb_adr_i)
				REG_CTRL:   ctrl_d = wb_dat_i[4:0];
				REG_MASK:   mask_d = wb_dat_i[NUM_EVT-1:0];
				REG_STATUS: evtClr = wb_dat_i[NUM_EVT-1:0];
				default:    ;
			endcase
		end
		// The address steps only after the strobe cycle, so the word lands where software aimed it.
		// step write address
		if (microcodeWe) begin
			cpuAddr_d = cpuAddr_q + 11'h001;
		end
		if (wbWrite && wb_adr_i == REG_MCADDR && wb_sel_i[1:0] == 2'h3) begin
			cpuAddr_d = wb_dat_i[MC_ADDR_W-1:0];
		end
		// A data write while one is still waiting for its slot is dropped.
		if (wbWrite && wb_adr_i == REG_MCDATA && wb_sel_i[1:0] == 2'h3 && !pending_q) begin
			cpuData_d = wb_dat_i[MC_WORD_W-1:0];
			pending_d = 1'b1;
		end
		if (mcWriteNow) begin
			pending_d = 1'b0;
		end
		irq_d = |(statusView & mask_q);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ack_q     <= 1'b0;
			rdat_q    <= 32'h00000000;
			ctrl_q    <= CTRL_RESET;
			mask_q    <= '0;
			cpuAddr_q <= '0;
			cpuData_q <= '0;
			pending_q <= 1'b0;
			irq_q     <= 1'b0;
		end else begin
			ack_q     <= ack_d;
			rdat_q    <= rdat_d;
			ctrl_q    <= ctrl_d;
			mask_q    <= mask_d;
			cpuAddr_q <= cpuAddr_d;
			cpuData_q <= cpuData_d;
			pending_q <= pending_d;
			irq_q     <= irq_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign irq      = irq_q;

	// ------------------------------------------------------------
	// Overflow detection and event flags
	// ------------------------------------------------------------
	logic overLevel, overLevel_q, ovfPulse_q, ovfPulse_d;

	assign overLevel = ($signed(effectSampleIn) > $signed(OVF_LIMIT)) ||
		($signed(effectSampleIn) < -$signed(OVF_LIMIT));

	always_comb begin
		ovfPulse_d = overLevel & ~overLevel_q;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			overLevel_q <= 1'b0;
			ovfPulse_q  <= 1'b0;
		end else begin
			overLevel_q <= overLevel;
			ovfPulse_q  <= ovfPulse_d;
		end
	end

	assign level_overflow_pulse = ovfPulse_q;

	eech_sticky_bits #(.N(NUM_EVT)) u_flags (
		.clk     (clk),
		.srst    (srst),
		.setBits (evtSet),
		.clrBits (evtClr),
		.flags   (evtFlags)
	);

	eech_sync2 #(.W(1)) u_ovf_sync (
		.clk  (clk),
		.srst (srst),
		.din  (evtFlags[EVT_OVF]),
		.dout (ovfSeen)
	);

	assign statusView = {evtFlags[NUM_EVT-1:1], ovfSeen};

	// ------------------------------------------------------------
	// Silence, fade and delay clear
	// ------------------------------------------------------------
	logic [11:0]           smpCnt_q, smpCnt_d;
	logic                  smpTick;
	logic [DLY_ADDR_W-1:0] clrAddr_q, clrAddr_d;
	logic                  clrWe_q, clrWe_d;
	logic                  clearDone;
	logic                  silenceCmd;
	logic [32:0]           scaled;
	logic [LEVEL_W-1:0]    sampleOut_q, levelCtrl_q;

	assign silenceCmd = ctrl_q[CTRL_SILENCE];
	assign smpTick    = smpCnt_q == SAMPLE_LAST;
	assign clearDone  = gate_q == GATE_CLEAR && clrAddr_q == DLY_LAST;

	always_comb begin
		smpCnt_d  = smpTick ? 12'h000 : smpCnt_q + 12'h001;
		gate_d    = gate_q;
		gain_d    = gain_q;
		clrAddr_d = clrAddr_q;
		clrWe_d   = 1'b0;
		case (gate_q)
			GATE_IDLE: begin
				// Fading back in avoids a click once the new algorithm runs.
				if (silenceCmd) begin
					gate_d = GATE_FADE;
				end else if (smpTick) begin
					gain_d = (gain_q > GAIN_FULL - FADE_STEP) ? GAIN_FULL : gain_q + FADE_STEP;
				end
			end
			GATE_FADE: begin
				if (gain_q == GAIN_ZERO) begin
					gate_d    = GATE_CLEAR;
					clrAddr_d = '0;
					clrWe_d   = 1'b1;
				end else if (smpTick) begin
					gain_d = (gain_q < FADE_STEP) ? GAIN_ZERO : gain_q - FADE_STEP;
				end
			end
			GATE_CLEAR: begin
				if (clearDone) begin
					gate_d = GATE_HOLD;
				end else begin
					clrAddr_d = clrAddr_q + 16'h0001;
					clrWe_d   = 1'b1;
				end
			end
			GATE_HOLD: begin
				if (!silenceCmd) begin
					gate_d = GATE_IDLE;
				end
			end
			default: gate_d = GATE_IDLE;
		endcase
	end

	assign scaled = $signed(effectSampleIn) * $signed({1'b0, gain_q});

	always_ff @(posedge clk) begin
		if (srst) begin
			smpCnt_q    <= 12'h000;
			gate_q      <= GATE_IDLE;
			gain_q      <= GAIN_ZERO;
			clrAddr_q   <= '0;
			clrWe_q     <= 1'b0;
			sampleOut_q <= '0;
			levelCtrl_q <= LEVEL_FULL_ATT;
		end else begin
			smpCnt_q    <= smpCnt_d;
			gate_q      <= gate_d;
			gain_q      <= gain_d;
			clrAddr_q   <= clrAddr_d;
			clrWe_q     <= clrWe_d;
			sampleOut_q <= scaled[31:16];
			levelCtrl_q <= ctrl_q[CTRL_MUTE] ? LEVEL_FULL_ATT : output_level_value;
		end
	end

	assign effectSampleOut = sampleOut_q;
	assign outputLevelCtrl = levelCtrl_q;
	assign delayClrWe      = clrWe_q;
	assign delayClrAddr    = clrAddr_q;

	// ------------------------------------------------------------
	// Microcode sequencing and shared memory writes
	// ------------------------------------------------------------
	logic [3:0]           slot_q, slot_d;
	logic [MC_ENG_W-1:0]  engAddr_q, engAddr_d;
	logic [MC_WORD_W-1:0] instr_q, instr_d;
	logic                 we_q, we_d;
	logic                 fetchPhase;

	assign fetchPhase = slot_q <= FETCH_LAST;
	assign mcWriteNow = pending_q && slot_q == WRITE_SLOT;
	assign evtSet     = {mcWriteNow, clearDone, ovfPulse_q};

	always_comb begin
		slot_d    = (slot_q == SLOT_LAST) ? 4'h0 : slot_q + 4'h1;
		engAddr_d = (slot_q == SLOT_LAST) ? engAddr_q + 8'h01 : engAddr_q;
		instr_d   = (slot_q == FETCH_LAST) ? microcodeWordIn : instr_q;
		we_d      = mcWriteNow;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			slot_q    <= 4'h0;
			engAddr_q <= '0;
			instr_q   <= '0;
			we_q      <= 1'b0;
		end else begin
			slot_q    <= slot_d;
			engAddr_q <= engAddr_d;
			instr_q   <= instr_d;
			we_q      <= we_d;
		end
	end

	assign microcode_mem_free = ~fetchPhase;
	assign microcodeMuxSel    = fetchPhase;
	assign microcode_addr_bus = microcodeMuxSel ? {ctrl_q[4:2], engAddr_q} : cpuAddr_q;
	assign microcodeWe        = we_q;
	assign microcodeWordOe    = we_q;
	assign microcodeWordOut   = cpuData_q;
	assign instrWord          = instr_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_mute_forces_atten:
		assert property ($past(ctrl_q[CTRL_MUTE]) |-> outputLevelCtrl == LEVEL_FULL_ATT)
		else $error("level not fully attenuated under mute");
	a_ovf_pulse_short:
		assert property (level_overflow_pulse |=> !level_overflow_pulse)
		else $error("overflow pulse longer than one cycle");
	a_ovf_flag_catch:
		assert property (level_overflow_pulse |=> evtFlags[EVT_OVF])
		else $error("overflow pulse not caught");
	a_ovf_sync_lag:
		assert property (ovfSeen == $past(evtFlags[EVT_OVF], 2))
		else $error("overflow view not two stages behind flag");
	a_we_when_free:
		assert property (microcodeWe |-> microcode_mem_free && !microcodeMuxSel)
		else $error("microcode write outside a free interval");
	a_write_addr_step:
		assert property (microcodeWe |=> cpuAddr_q == $past(cpuAddr_q) + 11'h001)
		else $error("write address did not step");
	a_cpu_addr_mux:
		assert property (!microcodeMuxSel |-> microcode_addr_bus == cpuAddr_q)
		else $error("processor address not on bus while select low");
	a_slot_interval:
		assert property ($changed(engAddr_q) |-> $past(slot_q) == SLOT_LAST ##1 $stable(engAddr_q) [*8])
		else $error("engine address interval wrong");
	a_clear_after_fade:
		assert property (delayClrWe |-> gain_q == GAIN_ZERO)
		else $error("delay cleared before fade reached silence");
	a_free_in_slot:
		assert property (slot_q == 4'h0 |-> !microcode_mem_free ##6 microcode_mem_free)
		else $error("free interval misplaced in slot");
endmodule
`default_nettype wire

/* File: eech_core_tb_top.sv */
`default_nettype none
module eech_core_tb_top;
	import eech_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, srst, wbCyc, wbStb, wbWe, wbAck, irq, ovfPulse, memFree, muxSel, mcOe, mcWe, dlyWe;
	logic [7:0]  wbAdr;
	logic [31:0] wbDat, wbDatO, rdv;
	logic [15:0] sampleIn, sampleOut, levelIn, levelCtrl, mcIn, mcOut, instr, dlyAddr;
	logic [10:0] mcAddr, adrHist1, adrHist2;
	logic        selPrev, seenRise;
	int          badCount, cmpCount, ovfCount, clrCount, slotCnt;

	eech_core #(.DELAY_WORDS(16), .FADE_STEP(16'h4000), .OVF_LIMIT(16'h7000)) eech_core_inst (
		.clk(clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irq(irq),
		.effectSampleIn(sampleIn), .effectSampleOut(sampleOut), .output_level_value(levelIn),
		.outputLevelCtrl(levelCtrl), .level_overflow_pulse(ovfPulse), .microcode_mem_free(memFree),
		.microcodeMuxSel(muxSel), .microcode_addr_bus(mcAddr), .microcodeWordIn(mcIn),
		.microcodeWordOut(mcOut), .microcodeWordOe(mcOe), .microcodeWe(mcWe), .instrWord(instr),
		.delayClrWe(dlyWe), .delayClrAddr(dlyAddr));
	eech_mcram_model eech_mcram_model_inst (.clk(clk), .microcodeMuxSel(muxSel), .microcode_addr_bus(mcAddr),
		.microcodeWordOut(mcOut), .microcodeWe(mcWe), .microcodeWordIn(mcIn));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic closeOut;
		if (badCount == 0 && cmpCount > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmpCount++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (wbAck !== 1'b1) begin
			badCount++;
			closeOut();
		end
		r = wbDatO;
		wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wbXfer(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a);
		wbXfer(1'b0, a, 32'h0, rdv);
	endtask
	// Polls until the masked bits of a register read as the wanted value.
	task automatic pollFor(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input int lim);
		int n;
		n = 0;
		do begin
			rd(a);
			n++;
		end while ((rdv & m) !== v && n < lim);
		if ((rdv & m) !== v) begin
			badCount++;
			closeOut();
		end
	endtask

	// Slot timing and the fetch/free split are watched on every cycle.
	always @(posedge clk) begin
		if (srst) begin
			ovfCount <= 0; clrCount <= 0; slotCnt <= 0; seenRise <= 1'b0; selPrev <= 1'b1;
		end else begin
			if (ovfPulse === 1'b1) ovfCount <= ovfCount + 1;
			if (dlyWe === 1'b1) begin
				clrCount <= clrCount + 1;
				chk({16'h0, dlyAddr}, clrCount & 32'hf, "clear address order");
			end
			slotCnt <= slotCnt + 1;
			selPrev <= muxSel;
			adrHist1 <= mcAddr;
			adrHist2 <= adrHist1;
			if (seenRise && !(muxSel === 1'b1 && selPrev === 1'b0)) begin
				chk({31'h0, memFree}, {31'h0, slotCnt >= MC_FETCH_CYC}, "mem free in slot");
				chk({31'h0, muxSel}, {31'h0, slotCnt < MC_FETCH_CYC}, "select in slot");
			end
			// The word latched at the end of the fetch half was read from the slot-four address.
			if (seenRise && muxSel === 1'b0 && selPrev === 1'b1) begin
				chk({16'h0, instr}, {16'h0, eech_mcram_model_inst.mem[adrHist2]}, "fetched word");
			end
			if (muxSel === 1'b1 && selPrev === 1'b0) begin
				slotCnt <= 1;
				if (seenRise) chk(slotCnt, MC_SLOT_CYC, "fetch slot period");
				seenRise <= 1'b1;
			end
		end
	end

	task automatic testReset;
		rd(REG_CTRL);
		chk(rdv, 32'h2, "ctrl reset");
		rd(REG_STATE);
		chk(rdv[2:0], 3'b100, "state reset");
		chk(levelCtrl, 16'hffff, "level at reset");
	endtask
	task automatic testLoad;
		wr(REG_MCADDR, 32'h010);
		wr(REG_MCDATA, 32'ha5c3);
		pollFor(REG_STATE, 32'h1, 32'h0, 20);
		wr(REG_MCDATA, 32'h3c5a);
		pollFor(REG_STATE, 32'h1, 32'h0, 20);
		chk(eech_mcram_model_inst.mem[16], 16'ha5c3, "first word");
		chk(eech_mcram_model_inst.mem[17], 16'h3c5a, "second word");
		chk(eech_mcram_model_inst.mem[18], 16'h0012, "word untouched");
		rd(REG_MCADDR);
		chk(rdv, 32'h012, "address stepped");
	endtask
	task automatic testMute;
		wr(REG_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk(levelCtrl, 16'h1234, "unmuted level");
		levelIn <= 16'h0abc;
		repeat (2) @(posedge clk);
		chk(levelCtrl, 16'h0abc, "level follows");
		wr(REG_CTRL, 32'h2);
		repeat (2) @(posedge clk);
		chk(levelCtrl, 16'hffff, "muted level");
		wr(REG_CTRL, 32'h0);
	endtask
	task automatic testIrq;
		wr(REG_MASK, 32'h0);
		rd(REG_STATUS);
		chk(rdv[2], 1'b1, "word written flag");
		chk(irq, 1'b0, "masked irq");
		wr(REG_MASK, 32'h4);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1, "unmasked irq");
		wr(REG_STATUS, 32'h4);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0, "cleared irq");
		wr(REG_MASK, 32'h0);
	endtask
	task automatic testOvf;
		int c0;
		c0 = ovfCount;
		@(posedge clk);
		sampleIn <= 16'h7100;
		repeat (3) @(posedge clk);
		sampleIn <= 16'h1000;
		repeat (10) @(posedge clk);
		chk(ovfCount - c0, 1, "one pulse per crossing");
		repeat (20) @(posedge clk);
		rd(REG_STATUS);
		chk(rdv[0], 1'b1, "sticky overflow");
		rd(REG_STATUS);
		chk(rdv[0], 1'b1, "still sticky");
		wr(REG_STATUS, 32'h1);
		repeat (4) @(posedge clk);
		rd(REG_STATUS);
		chk(rdv[0], 1'b0, "overflow cleared");
	endtask
	task automatic testGate;
		int c0, n;
		c0 = clrCount;
		n = 0;
		// Gain must first ramp to full, or the fade below would have nothing to do.
		pollFor(REG_STATE, 32'hffff0000, 32'hffff0000, 8000);
		chk(sampleOut, 16'h0fff, "full gain output");
		wr(REG_CTRL, 32'h15);
		pollFor(REG_STATE, 32'hffff0000, 32'h7fff0000, 4000);
		pollFor(REG_STATUS, 32'h2, 32'h2, 8000);
		chk(clrCount - c0, 16, "delay words cleared");
		rd(REG_STATE);
		chk(rdv[31:16], 16'h0, "gain faded");
		chk(sampleOut, 16'h0, "silent output");
		do begin
			@(posedge clk);
			n++;
		end while (muxSel !== 1'b1 && n < 30);
		chk(mcAddr[10:8], 3'h5, "routine bits on address");
		wr(REG_CTRL, 32'h14);
		wr(REG_STATUS, 32'h2);
	endtask

	initial begin
		srst = 1'b1; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = 8'h00; wbDat = 32'h0;
		sampleIn = 16'h1000; levelIn = 16'h1234; badCount = 0; cmpCount = 0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		testReset();
		testLoad();
		testMute();
		testIrq();
		testOvf();
		testGate();
		closeOut();
	end
endmodule
`default_nettype wire

/* File: eech_mcram_model.sv */
`default_nettype none
module eech_mcram_model
	import eech_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 microcodeMuxSel,
	input  wire logic [MC_ADDR_W-1:0] microcode_addr_bus,
	input  wire logic [MC_WORD_W-1:0] microcodeWordOut,
	input  wire logic                 microcodeWe,
	output var  logic [MC_WORD_W-1:0] microcodeWordIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [MC_WORD_W-1:0] mem [0:(1<<MC_ADDR_W)-1];
	initial begin
		for (int i = 0; i < (1 << MC_ADDR_W); i++) begin
			mem[i] = MC_WORD_W'(i);
		end
		microcodeWordIn = '0;
	end
	always @(posedge clk) begin
		if (microcodeWe === 1'b1) begin
			mem[microcode_addr_bus] <= microcodeWordOut;
		end
		// engine fetch.
		// Outside the fetch half the bus toggles, so a late sample never looks like a valid word.
		if (microcodeMuxSel === 1'b1) begin
			microcodeWordIn <= mem[microcode_addr_bus];
		end else begin
			microcodeWordIn <= ~microcodeWordIn;
		end
	end
endmodule
`default_nettype wire

/* File: eech_pkg.sv */
`default_nettype none
package eech_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int MC_SLOT_NS     = 125;
	localparam int MC_SLOT_CYC    = (MC_SLOT_NS * CLK_MHZ) / 1000;
	localparam int MC_FETCH_CYC   = MC_SLOT_CYC / 2;
	localparam int SAMPLE_US      = 30;
	localparam int SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int MC_ENG_W       = 8;
	localparam int MC_RTN_W       = 3;
	localparam int MC_ADDR_W      = MC_ENG_W + MC_RTN_W;
	localparam int MC_WORD_W      = 16;
	localparam int LEVEL_W        = 16;
	localparam int DLY_ADDR_W     = 16;
	localparam int NUM_EVT        = 3;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK   = 8'h08;
	localparam logic [7:0] REG_MCADDR = 8'h0c;
	localparam logic [7:0] REG_MCDATA = 8'h10;
	localparam logic [7:0] REG_STATE  = 8'h14;
	localparam int CTRL_SILENCE   = 0;
	localparam int CTRL_MUTE      = 1;
	localparam int CTRL_RTN_LSB   = 2;
	localparam int EVT_OVF        = 0;
	localparam int EVT_CLEARED    = 1;
	localparam int EVT_MCWRITTEN  = 2;
	localparam int STATE_PENDING  = 0;
	localparam int STATE_GATING   = 1;
	localparam int STATE_MUTED    = 2;
	localparam int STATE_GAIN_LSB = 16;
	localparam logic [4:0]  CTRL_RESET     = 5'h02;
	localparam logic [15:0] GAIN_FULL      = 16'hffff;
	localparam logic [15:0] GAIN_ZERO      = 16'h0000;
	localparam logic [15:0] LEVEL_FULL_ATT = 16'hffff;

	typedef enum logic [3:0] {
		GATE_IDLE  = 4'h1,
		GATE_FADE  = 4'h2,
		GATE_CLEAR = 4'h4,
		GATE_HOLD  = 4'h8
	} eech_gate_state_t;
endpackage
`default_nettype wire

/* File: eech_sticky_bits.sv */
`default_nettype none
module eech_sticky_bits #(
	parameter int N = 3
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [N-1:0] setBits,
	input  wire logic [N-1:0] clrBits,
	output logic      [N-1:0] flags
);
	logic [N-1:0] flags_q;
	logic [N-1:0] flags_d;

	// A set in the same cycle as a clear must survive, or an event is lost.
	for (genvar i = 0; i < N; i++) begin : g_bit
		always_comb begin
			flags_d[i] = setBits[i] | (flags_q[i] & ~clrBits[i]);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;
endmodule
`default_nettype wire

/* File: eech_sync2.sv */
`default_nettype none
module eech_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] stage1_q;
	logic [W-1:0] stage1_d;
	logic [W-1:0] stage2_q;
	logic [W-1:0] stage2_d;

	always_comb begin
		stage1_d = din;
		stage2_d = stage1_q;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			stage1_q <= '0;
			stage2_q <= '0;
		end else begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
		end
	end

	assign dout = stage2_q;
endmodule
`default_nettype wire
